//--- inc/rtcc_pkg.sv
package rtcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFF    = 8'h04;
  localparam logic [7:0] CAPTURE_OFF = 8'h08;
  localparam logic [7:0] ALARM_OFF   = 8'h0C;
  localparam logic [7:0] STATUS_OFF  = 8'h10;
  localparam logic [7:0] MASK_OFF    = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int unsigned OSC_EN_BIT   = 7;
  localparam int unsigned DET_EN_BIT   = 6;
  localparam int unsigned FAIL_BIT     = 5;
  localparam int unsigned RUN_BIT      = 4;
  localparam int unsigned AEN_BIT      = 3;
  localparam int unsigned AFLAG_BIT    = 2;
  localparam int unsigned LOAD_BIT     = 1;
  localparam int unsigned SNAP_BIT     = 0;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask fields
  localparam int unsigned IRQ_ALARM_BIT = 0;
  localparam int unsigned IRQ_FAIL_BIT  = 1;
  localparam int unsigned IRQ_W         = 2;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MISS_TIME_NS  = 100_000;
  localparam int unsigned MISS_CYCLES   = (MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // bus
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic {BUS_IDLE, BUS_ACT} rtcc_bus_st_t;

endpackage

//--- inc/rtcc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rtcc_tmr_if #(parameter int unsigned TW = 32);
  logic          osc_en;
  logic          det_en;
  logic          run;
  logic          alarm_en;
  logic          autoreset;
  logic          alarm_clr;
  logic          load_req;
  logic          snap_req;
  logic [TW-1:0] load_value;
  logic [TW-1:0] alarm_value;
  logic          load_done;
  logic          snap_done;
  logic [TW-1:0] snap_value;
  logic          alarm_flag;
  logic          alarm_hit;
  logic          fail_pulse;

  modport ctrl (output osc_en, det_en, run, alarm_en, autoreset, alarm_clr, load_req,
                snap_req, load_value, alarm_value,
                input load_done, snap_done, snap_value, alarm_flag, alarm_hit, fail_pulse);
  modport core (input osc_en, det_en, run, alarm_en, autoreset, alarm_clr, load_req,
                snap_req, load_value, alarm_value,
                output load_done, snap_done, snap_value, alarm_flag, alarm_hit, fail_pulse);
endinterface
`default_nettype wire

//--- design/rtcc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rtcc_timer #(
  parameter int unsigned TW = 32
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // oscillator output, sampled
  input  wire logic osc_i,
  // control side
  rtcc_tmr_if.core  tif
);

  localparam int unsigned MW = $clog2(rtcc_pkg::MISS_CYCLES + 1);
  localparam logic [MW-1:0] MISS_MAX = MW'(rtcc_pkg::MISS_CYCLES);

  logic          osc_q;
  logic [TW-1:0] timer;
  logic [MW-1:0] miss_cnt;
  logic          ar_pend;

  wire tick    = osc_i & ~osc_q;
  wire armed   = tif.det_en & tif.osc_en;
  wire stable  = osc_i == osc_q;
  wire hit     = tick & tif.run & tif.alarm_en & (timer == tif.alarm_value);

  ////////////////////////////////////////////////////////////////////////////
  // missing clock detector
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_q          <= 1'b0;
      miss_cnt       <= '0;
      tif.fail_pulse <= 1'b0;
    end else begin
      osc_q <= osc_i;
      if (!armed || !stable) begin
        miss_cnt <= '0;
      end else if (miss_cnt != MISS_MAX) begin
        miss_cnt <= miss_cnt + MW'(1);
      end
      tif.fail_pulse <= armed & stable & (miss_cnt == MISS_MAX - MW'(1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer, load and snapshot
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer          <= '0;
      tif.load_done  <= 1'b0;
      tif.snap_done  <= 1'b0;
      tif.snap_value <= '0;
    end else begin
      tif.load_done <= tif.load_req;
      tif.snap_done <= tif.snap_req;
      if (tif.snap_req) begin
        tif.snap_value <= timer;
      end
      if (tif.load_req) begin
        timer <= tif.load_value;
      end else if (tick && ar_pend) begin
        timer <= '0;
      end else if (tick && tif.run) begin
        timer <= timer + TW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm flag and auto reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tif.alarm_flag <= 1'b0;
      tif.alarm_hit  <= 1'b0;
      ar_pend        <= 1'b0;
    end else begin
      tif.alarm_hit <= hit;
      if (hit) begin
        tif.alarm_flag <= 1'b1;
      end else if (tick || tif.alarm_clr) begin
        tif.alarm_flag <= 1'b0;
      end
      if (tick && tif.alarm_flag && !hit) begin
        ar_pend <= tif.autoreset;
      end else if (tick || tif.load_req) begin
        ar_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_RUN_HOLD: assert property (!tif.run && !tif.load_req && !ar_pend |=> $stable(timer))
    else $error("timer moved while stopped");
  AST_DET_OFF: assert property (!armed |-> ##1 !tif.fail_pulse)
    else $error("fail pulse with detector disarmed");
  AST_MISS_TIME: assert property (tif.fail_pulse |-> miss_cnt == MISS_MAX && $past(stable))
    else $error("fail pulse before stuck time");
  AST_LOAD: assert property (tif.load_req |=> timer == $past(tif.load_value) && tif.load_done)
    else $error("timer load wrong");
  AST_SNAP: assert property (tif.snap_req |=> tif.snap_value == $past(timer) && tif.snap_done)
    else $error("snapshot wrong");
  AST_ALARM_GATE: assert property (!tif.alarm_en |=> !tif.alarm_hit)
    else $error("alarm while disabled");

  COV_ALARM: cover property (tif.alarm_hit ##[1:100] tif.alarm_flag == 1'b0);
  COV_FAIL: cover property (tif.fail_pulse);
  COV_AUTORST: cover property (ar_pend ##[1:100] timer == '0);

endmodule
`default_nettype wire

//--- design/rtcc_ctrl.sv
// Contract
// - bit 7 turns oscillator on, reset off
// - bit 6 arms missing clock detector
// - detector sets fail flag, software clears
// - fail flag undefined while oscillator off
// - bit 4 runs timer, else holds; a pending auto reset still clears it while stopped
// - bit 3 enables alarms; write clears flag
// - bit 2 reads alarm event flag
// - bit 2 write stores auto reset enable
// - control at 0x04, resets to zero
// - bit 1 loads timer, clears when done
// - bit 0 snapshots timer, clears when done
// - fail after 100 us stuck level
`timescale 1ns/1ps
`default_nettype none
module rtcc_ctrl #(
  parameter int unsigned TW = 32
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // oscillator
  input  wire logic        osc_clk_i,
  output var  logic        osc_enable_o,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic [31:0] hrdata_o,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  // interrupt
  output var  logic        irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  rtcc_tmr_if #(.TW(TW)) tif ();

  rtcc_pkg::rtcc_bus_st_t state;
  logic [7:0]    addr_q;
  logic          write_q;
  logic          det_en;
  logic          osc_fail;
  logic          run;
  logic          alarm_en;
  logic          autoreset;
  logic          load_pend;
  logic          snap_pend;
  logic [TW-1:0] capture;
  logic [TW-1:0] alarm_value;
  logic [rtcc_pkg::IRQ_W-1:0] status;
  logic [rtcc_pkg::IRQ_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire take     = hsel_i & hready_i & (htrans_i == rtcc_pkg::HTRANS_NONSEQ);
  wire active   = state == rtcc_pkg::BUS_ACT;
  wire wr_en    = active & write_q;
  wire rd_en    = active & ~write_q;
  wire wr_ctrl  = wr_en & (addr_q == rtcc_pkg::CTRL_OFF);
  wire wr_capt  = wr_en & (addr_q == rtcc_pkg::CAPTURE_OFF);
  wire wr_alarm = wr_en & (addr_q == rtcc_pkg::ALARM_OFF);
  wire wr_stat  = wr_en & (addr_q == rtcc_pkg::STATUS_OFF);
  wire wr_mask  = wr_en & (addr_q == rtcc_pkg::MASK_OFF);

  wire [7:0] ctrl_rd = {osc_enable_o, det_en, osc_fail, run, alarm_en,
                        tif.alarm_flag, load_pend, snap_pend};

  wire [rtcc_pkg::IRQ_W-1:0] irq_set;
  wire [rtcc_pkg::IRQ_W-1:0] irq_clr = wr_stat ? hwdata_i[rtcc_pkg::IRQ_W-1:0] : '0;
  wire [rtcc_pkg::IRQ_W-1:0] next_status = (status & ~irq_clr) | irq_set;

  assign irq_set[rtcc_pkg::IRQ_ALARM_BIT] = tif.alarm_hit;
  // ignore fail flag while oscillator off
  assign irq_set[rtcc_pkg::IRQ_FAIL_BIT]  = tif.fail_pulse & osc_enable_o;

  wire [31:0] rd_mux =
      (addr_q == rtcc_pkg::CTRL_OFF)    ? {24'h00_0000, ctrl_rd} :
      (addr_q == rtcc_pkg::CAPTURE_OFF) ? 32'(capture) :
      (addr_q == rtcc_pkg::ALARM_OFF)   ? 32'(alarm_value) :
      (addr_q == rtcc_pkg::STATUS_OFF)  ? {30'h0000_0000, status} :
      (addr_q == rtcc_pkg::MASK_OFF)    ? {30'h0000_0000, mask} :
                                          rtcc_pkg::WORD_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state per transfer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state       <= rtcc_pkg::BUS_IDLE;
      addr_q      <= 8'h00;
      write_q     <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o    <= rtcc_pkg::WORD_RESET;
      hresp_o     <= 1'b0;
    end else begin
      case (state)
        rtcc_pkg::BUS_IDLE: begin
          if (take) begin
            state       <= rtcc_pkg::BUS_ACT;
            addr_q      <= haddr_i[7:0];
            write_q     <= hwrite_i;
            hreadyout_o <= 1'b0;
          end
        end
        default: begin
          state       <= rtcc_pkg::BUS_IDLE;
          hreadyout_o <= 1'b1;
          if (rd_en) begin
            hrdata_o <= rd_mux;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_enable_o <= rtcc_pkg::CTRL_RESET[rtcc_pkg::OSC_EN_BIT];
      det_en       <= rtcc_pkg::CTRL_RESET[rtcc_pkg::DET_EN_BIT];
      run          <= rtcc_pkg::CTRL_RESET[rtcc_pkg::RUN_BIT];
      alarm_en     <= rtcc_pkg::CTRL_RESET[rtcc_pkg::AEN_BIT];
      autoreset    <= rtcc_pkg::CTRL_RESET[rtcc_pkg::AFLAG_BIT];
    end else if (wr_ctrl) begin
      osc_enable_o <= hwdata_i[rtcc_pkg::OSC_EN_BIT];
      det_en       <= hwdata_i[rtcc_pkg::DET_EN_BIT];
      run          <= hwdata_i[rtcc_pkg::RUN_BIT];
      alarm_en     <= hwdata_i[rtcc_pkg::AEN_BIT];
      // bit 2 write is auto reset
      autoreset    <= hwdata_i[rtcc_pkg::AFLAG_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_fail  <= rtcc_pkg::CTRL_RESET[rtcc_pkg::FAIL_BIT];
      load_pend <= rtcc_pkg::CTRL_RESET[rtcc_pkg::LOAD_BIT];
      snap_pend <= rtcc_pkg::CTRL_RESET[rtcc_pkg::SNAP_BIT];
    end else begin
      if (tif.fail_pulse) begin
        osc_fail <= 1'b1;
      end else if (wr_ctrl) begin
        osc_fail <= hwdata_i[rtcc_pkg::FAIL_BIT];
      end
      if (wr_ctrl && hwdata_i[rtcc_pkg::LOAD_BIT]) begin
        load_pend <= 1'b1;
      end else if (tif.load_done) begin
        load_pend <= 1'b0;
      end
      if (wr_ctrl && hwdata_i[rtcc_pkg::SNAP_BIT]) begin
        snap_pend <= 1'b1;
      end else if (tif.snap_done) begin
        snap_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture, alarm value, interrupts
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      capture     <= TW'(rtcc_pkg::WORD_RESET);
      alarm_value <= TW'(rtcc_pkg::WORD_RESET);
      status      <= rtcc_pkg::IRQ_RESET;
      mask        <= rtcc_pkg::IRQ_RESET;
      irq_o       <= 1'b0;
    end else begin
      if (tif.snap_done) begin
        capture <= tif.snap_value;
      end else if (wr_capt) begin
        capture <= hwdata_i[TW-1:0];
      end
      if (wr_alarm) begin
        alarm_value <= hwdata_i[TW-1:0];
      end
      if (wr_mask) begin
        mask <= hwdata_i[rtcc_pkg::IRQ_W-1:0];
      end
      status <= next_status;
      irq_o  <= |(next_status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer core
  assign tif.osc_en      = osc_enable_o;
  assign tif.det_en      = det_en;
  assign tif.run         = run;
  assign tif.alarm_en    = alarm_en;
  assign tif.autoreset   = autoreset;
  assign tif.alarm_clr   = wr_ctrl;
  assign tif.load_req    = wr_ctrl & hwdata_i[rtcc_pkg::LOAD_BIT];
  assign tif.snap_req    = wr_ctrl & hwdata_i[rtcc_pkg::SNAP_BIT];
  assign tif.load_value  = capture;
  assign tif.alarm_value = alarm_value;

  rtcc_timer #(.TW(TW)) u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .osc_i     (osc_clk_i),
    .tif       (tif.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_OSC_EN: assert property (wr_ctrl |=> osc_enable_o == $past(hwdata_i[7]))
    else $error("oscillator enable not stored");
  AST_FAIL_SET: assert property (tif.fail_pulse |=> osc_fail ##1 osc_fail || $past(wr_ctrl))
    else $error("fail flag not set");
  AST_FAIL_IRQ: assert property (!osc_enable_o && !tif.alarm_hit && !wr_stat |=>
                                 status[rtcc_pkg::IRQ_FAIL_BIT] == $past(status[1]))
    else $error("fail event while oscillator off");
  AST_AEN_CLR: assert property (wr_ctrl && !u_timer.hit |=> !tif.alarm_flag)
    else $error("alarm flag not cleared");
  AST_RD_FLAG: assert property (rd_en && addr_q == rtcc_pkg::CTRL_OFF |=>
                                hrdata_o[2] == $past(tif.alarm_flag) && hrdata_o[31:8] == '0)
    else $error("bit 2 read wrong");
  AST_AUTORST: assert property (wr_ctrl |=> autoreset == $past(hwdata_i[2]))
    else $error("auto reset enable not stored");
  AST_BUS_WAIT: assert property (take && !active |=> !hreadyout_o ##1 hreadyout_o)
    else $error("bus answer timing wrong");
  AST_PEND: assert property (wr_ctrl && hwdata_i[1] |=> load_pend ##1 !load_pend)
    else $error("load pending bit wrong");

  COV_LOAD: cover property (wr_ctrl && hwdata_i[1]);
  COV_SNAP_RD: cover property (tif.snap_done ##[1:20] rd_en && addr_q == rtcc_pkg::CAPTURE_OFF);
  COV_IRQ: cover property (irq_o);

endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  logic        clk_i;
  logic        reset_n_i;
  logic        osc_clk_i;
  logic        osc_enable_o;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        irq_o;
  logic [31:0] rv;
  int          mismatches;
  int          checks;

  rtcc_ctrl rtcc_ctrl_inst (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .osc_clk_i    (osc_clk_i),
    .osc_enable_o (osc_enable_o),
    .hsel_i       (hsel_i),
    .haddr_i      (haddr_i),
    .htrans_i     (htrans_i),
    .hwrite_i     (hwrite_i),
    .hsize_i      (hsize_i),
    .hwdata_i     (hwdata_i),
    .hready_i     (hreadyout_o),
    .hrdata_o     (hrdata_o),
    .hreadyout_o  (hreadyout_o),
    .hresp_o      (hresp_o),
    .irq_o        (irq_o)
  );

  always #25 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // bus master
  task automatic wait_rdy(output logic [31:0] r);
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic [31:0] dummy;
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h00_0000, a};
    hwrite_i <= w;
    htrans_i <= rtcc_pkg::HTRANS_NONSEQ;
    wait_rdy(dummy);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy(r);
    `CHK(hresp_o, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0000_0000, r);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      osc_clk_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      osc_clk_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    `CHK(osc_enable_o, 1'b0)
    `CHK(irq_o, 1'b0)
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_0000)
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, rv);
    `CHK(rv, 32'h0000_0000)
  endtask

  task automatic t_ctrl_rw;
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_00AC);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_00A8)
    `CHK(osc_enable_o, 1'b1)
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0000);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_0000)
    `CHK(osc_enable_o, 1'b0)
  endtask

  task automatic t_timer;
    wr(rtcc_pkg::CAPTURE_OFF, 32'h0000_0010);
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0082);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_0080)
    wr(rtcc_pkg::CAPTURE_OFF, 32'hFFFF_0000);
    tick(2);
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0081);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_0080)
    rd(rtcc_pkg::CAPTURE_OFF, rv);
    `CHK(rv, 32'h0000_0010)
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0090);
    tick(3);
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0091);
    rd(rtcc_pkg::CAPTURE_OFF, rv);
    `CHK(rv, 32'h0000_0013)
  endtask

  task automatic t_alarm;
    int n;
    n = 0;
    wr(rtcc_pkg::ALARM_OFF, 32'h0000_0016);
    wr(rtcc_pkg::MASK_OFF, 32'h0000_0001);
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0098);
    rv = 32'h0000_0000;
    while (rv[0] !== 1'b1 && n < 5) begin
      tick(1);
      n++;
      rd(rtcc_pkg::STATUS_OFF, rv);
    end
    `CHK((n == 3 || n == 4), 1'b1)
    `CHK(irq_o, 1'b1)
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_009C)
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0098);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_0098)
    wr(rtcc_pkg::MASK_OFF, 32'h0000_0000);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(rtcc_pkg::STATUS_OFF, 32'h0000_0001);
    rd(rtcc_pkg::STATUS_OFF, rv);
    `CHK(rv, 32'h0000_0000)
  endtask

  task automatic t_detect;
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0080);
    wr(rtcc_pkg::MASK_OFF, 32'h0000_0002);
    repeat (rtcc_pkg::MISS_CYCLES + 100) @(posedge clk_i);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_0080)
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_00C0);
    repeat (rtcc_pkg::MISS_CYCLES + 100) @(posedge clk_i);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_00E0)
    rd(rtcc_pkg::STATUS_OFF, rv);
    `CHK(rv, 32'h0000_0002)
    `CHK(irq_o, 1'b1)
    wr(rtcc_pkg::CTRL_OFF, 32'h0000_0080);
    rd(rtcc_pkg::CTRL_OFF, rv);
    `CHK(rv, 32'h0000_0080)
    wr(rtcc_pkg::STATUS_OFF, 32'h0000_0002);
    rd(rtcc_pkg::STATUS_OFF, rv);
    `CHK(rv, 32'h0000_0000)
    `CHK(irq_o, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and sequence
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    results();
  end

  initial begin
    clk_i      = 1'b0;
    reset_n_i  = 1'b0;
    osc_clk_i  = 1'b0;
    hsel_i     = 1'b0;
    haddr_i    = 32'h0000_0000;
    htrans_i   = 2'h0;
    hwrite_i   = 1'b0;
    hsize_i    = 3'h2;
    hwdata_i   = 32'h0000_0000;
    mismatches = 0;
    checks     = 0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_ctrl_rw();
    t_timer();
    t_alarm();
    t_detect();
    results();
  end
endmodule
`default_nettype wire
